//--- pkg/wpc_pkg.sv
package wpc_pkg;

  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned TB_MAX_MHZ = 20;
  localparam int unsigned TB_DIV = (CLK_MHZ + TB_MAX_MHZ - 1) / TB_MAX_MHZ;
  localparam int unsigned PCI_RST_MIN_CLKS = 30;

  localparam logic [3:0] ADDR_MEM_CTRL = 4'h0;
  localparam logic [3:0] ADDR_WAKE_CFG = 4'h4;
  localparam logic [3:0] ADDR_LED_CFG = 4'h8;

  localparam int unsigned MC_DATA = 0;
  localparam int unsigned MC_CLK = 1;
  localparam int unsigned MC_SEL = 2;
  localparam int unsigned MC_PRESENT = 3;
  localparam int unsigned MC_BUSY = 4;

  localparam int unsigned WC_PHY_POL = 0;
  localparam int unsigned WC_WAKE_POL = 1;
  localparam int unsigned WC_GATE = 2;
  localparam int unsigned WC_TOTEM = 3;
  localparam int unsigned WC_MODE = 4;
  localparam int unsigned WC_PIN_EN = 5;
  localparam int unsigned WC_LINK_MODE = 6;
  localparam int unsigned WC_VALID = 8;
  localparam int unsigned WC_WAKE_MODE = 9;
  localparam int unsigned WC_WAKE_PEND = 10;
  localparam logic [6:0] WAKE_CFG_RST = 7'h00;

  localparam int unsigned LED_FIELD_W = 4;
  localparam int unsigned LED_HIGH_BIT = 2;
  localparam logic [15:0] LED_CFG_RST = 16'h3210;

  localparam logic [8:0] MEM_READ_CMD = 9'h180;
  localparam int unsigned CMD_BITS = 9;
  localparam int unsigned DATA_BITS = 16;

endpackage

//--- hdl/wpc_pin_control.sv
`timescale 1ns/1ns
module wpc_pin_control #(
  parameter int unsigned BOOT_HI_W = 4
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        pciRstN,
  input  wire logic        powerGoodIn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  netStatus,
  input  wire logic        ledRxPinIn,
  input  wire logic        ledTxPinIn,
  output logic      [3:0]  ledOut,
  output logic      [3:0]  ledOe,
  output logic             serialMemSelect,
  input  wire logic        timebaseSelect,
  input  wire logic        timebaseExtClock,
  input  wire logic        wakeFrameDetected,
  input  wire logic        linkChangeDetected,
  output logic             remoteWakeOut,
  output logic             remoteWakeOe,
  output logic             wakeModeIndicator,
  output logic             phyResetOut,
  output logic             pciPinsFloat,
  input  wire logic        bootAccessStart,
  input  wire logic [BOOT_HI_W-1:0] bootAddrHigh,
  output logic      [7:0]  bootAddrShared,
  output logic             bootAddrStrobe
);

  if (BOOT_HI_W < 1 || BOOT_HI_W > 8) begin : g_chk
    $error("BOOT_HI_W must be 1 to 8");
  end

  typedef enum logic [1:0] {LD_IDLE, LD_CMD, LD_DATA} wpc_ld_t;

  typedef struct packed {
    logic        waitReq;
    logic [31:0] readData;
    logic [2:0]  memCtrl;
    logic        memPresent;
    logic [6:0]  wakeCfg;
    logic        cfgValid;
    logic [15:0] ledCfg;
    logic        rstHeld;
    wpc_ld_t     ld;
    logic [4:0]  bitCnt;
    logic        phase;
    logic [8:0]  cmdSh;
    logic [15:0] dataSh;
    logic        ldSel;
    logic        ldClk;
    logic        ldDi;
    logic [1:0]  divCnt;
    logic        extPrev;
    logic        wakePend;
    logic [1:0]  bootPh;
    logic [3:0]  ledOut;
    logic [3:0]  ledOe;
    logic        memSel;
    logic        rwuOut;
    logic        rwuOe;
    logic        wakeInd;
    logic        phyRst;
    logic        pciFloat;
    logic [7:0]  bootAddr;
    logic        bootStrobe;
  } wpc_st_t;

  wpc_st_t st_q;
  wpc_st_t st_d;

  logic       intRst;
  logic       tbTick;
  logic       memActive;
  logic       wakeMode;
  logic [3:0] ledOn;
  logic       wakeLevel;
  logic       wakeDrive;
  logic       hostWrite;

  assign intRst = !pciRstN && powerGoodIn;
  assign tbTick = timebaseSelect ? (timebaseExtClock && !st_q.extPrev)
                                 : (st_q.divCnt == 2'd0);
  assign memActive = (st_q.ld != LD_IDLE) || st_q.memCtrl[wpc_pkg::MC_SEL];
  assign wakeMode = !powerGoodIn &&
                    (st_q.wakeCfg[wpc_pkg::WC_PIN_EN] ||
                     st_q.wakeCfg[wpc_pkg::WC_MODE]);
  assign hostWrite = avs_write && !st_q.waitReq;

  for (genvar i = 0; i < 4; i++) begin : g_led
    assign ledOn[i] = netStatus[st_q.ledCfg[i*wpc_pkg::LED_FIELD_W +: 2]];
  end

  assign wakeLevel = st_q.wakePend ~^ st_q.wakeCfg[wpc_pkg::WC_WAKE_POL];
  assign wakeDrive = st_q.cfgValid &&
                     !(st_q.wakeCfg[wpc_pkg::WC_GATE] && !powerGoodIn);

  always_comb begin
    st_d = st_q;
    // Time base divider and external edge history
    st_d.extPrev = timebaseExtClock;
    if (st_q.divCnt == 2'(wpc_pkg::TB_DIV - 1)) begin
      st_d.divCnt = 2'd0;
    end else begin
      st_d.divCnt = st_q.divCnt + 2'd1;
    end

    // Avalon slave: one wait cycle, then commit
    st_d.waitReq = 1'b1;
    if ((avs_read || avs_write) && st_q.waitReq) begin
      st_d.waitReq = 1'b0;
      st_d.readData = 32'h0000_0000;
      unique case (avs_address)
        wpc_pkg::ADDR_MEM_CTRL: begin
          st_d.readData[wpc_pkg::MC_DATA] = ledTxPinIn;
          st_d.readData[wpc_pkg::MC_CLK] = st_q.memCtrl[wpc_pkg::MC_CLK];
          st_d.readData[wpc_pkg::MC_SEL] = st_q.memCtrl[wpc_pkg::MC_SEL];
          st_d.readData[wpc_pkg::MC_PRESENT] = st_q.memPresent;
          st_d.readData[wpc_pkg::MC_BUSY] = st_q.ld != LD_IDLE;
        end
        wpc_pkg::ADDR_WAKE_CFG: begin
          st_d.readData[6:0] = st_q.wakeCfg;
          st_d.readData[wpc_pkg::WC_VALID] = st_q.cfgValid;
          st_d.readData[wpc_pkg::WC_WAKE_MODE] = wakeMode;
          st_d.readData[wpc_pkg::WC_WAKE_PEND] = st_q.wakePend;
        end
        wpc_pkg::ADDR_LED_CFG: st_d.readData[15:0] = st_q.ledCfg;
        default: st_d.readData = 32'h0000_0000;
      endcase
    end
    if (hostWrite && avs_byteenable[0]) begin
      unique case (avs_address)
        wpc_pkg::ADDR_MEM_CTRL: st_d.memCtrl = avs_writedata[2:0];
        wpc_pkg::ADDR_WAKE_CFG: begin
          st_d.wakeCfg = avs_writedata[6:0];
          st_d.cfgValid = 1'b1;
        end
        wpc_pkg::ADDR_LED_CFG: st_d.ledCfg[7:0] = avs_writedata[7:0];
        default: st_d.cfgValid = st_q.cfgValid;
      endcase
    end
    if (hostWrite && avs_byteenable[1] &&
        avs_address == wpc_pkg::ADDR_LED_CFG) begin
      st_d.ledCfg[15:8] = avs_writedata[15:8];
    end

    // One-word memory read (9 command bits, 16 data bits), paced by the time base
    st_d.rstHeld = intRst;
    unique case (st_q.ld)
      LD_IDLE: begin
        if (st_q.rstHeld && !intRst && pciRstN) begin
          if (st_q.memPresent) begin
            st_d.ld = LD_CMD;
            st_d.ldSel = 1'b1;
            st_d.ldClk = 1'b0;
            st_d.phase = 1'b0;
            st_d.bitCnt = 5'd0;
            st_d.cmdSh = wpc_pkg::MEM_READ_CMD;
            st_d.ldDi = wpc_pkg::MEM_READ_CMD[8];
          end else begin
            st_d.cfgValid = 1'b1;
          end
        end
      end
      LD_CMD: begin
        if (tbTick) begin
          st_d.phase = !st_q.phase;
          st_d.ldClk = !st_q.phase;
          if (st_q.phase) begin
            st_d.cmdSh = {st_q.cmdSh[7:0], 1'b0};
            st_d.ldDi = st_q.cmdSh[7];
            if (st_q.bitCnt == 5'(wpc_pkg::CMD_BITS - 1)) begin
              st_d.ld = LD_DATA;
              st_d.bitCnt = 5'd0;
              st_d.ldDi = 1'b0;
            end else begin
              st_d.bitCnt = st_q.bitCnt + 5'd1;
            end
          end
        end
      end
      LD_DATA: begin
        if (tbTick) begin
          st_d.phase = !st_q.phase;
          st_d.ldClk = !st_q.phase;
          if (!st_q.phase) begin
            st_d.dataSh = {st_q.dataSh[14:0], ledTxPinIn};
          end else if (st_q.bitCnt == 5'(wpc_pkg::DATA_BITS - 1)) begin
            st_d.ld = LD_IDLE;
            st_d.ldSel = 1'b0;
            st_d.wakeCfg = st_q.dataSh[6:0];
            st_d.cfgValid = 1'b1;
          end else begin
            st_d.bitCnt = st_q.bitCnt + 5'd1;
          end
        end
      end
      default: st_d.ld = LD_IDLE;
    endcase

    // Presence flag: last sample while reset low with power good, held after
    if (intRst) begin
      st_d.memPresent = ledRxPinIn;
    end

    // Remote wake request, set wins over reset clear
    if (intRst) begin
      st_d.wakePend = 1'b0;
    end
    if ((wakeMode && wakeFrameDetected) ||
        (st_q.wakeCfg[wpc_pkg::WC_LINK_MODE] && linkChangeDetected)) begin
      st_d.wakePend = 1'b1;
    end

    // Shared LED and serial memory pins
    for (int i = 0; i < 4; i++) begin
      if (st_q.ledCfg[i*wpc_pkg::LED_FIELD_W + wpc_pkg::LED_HIGH_BIT]) begin
        st_d.ledOut[i] = ledOn[i];
        st_d.ledOe[i] = 1'b1;
      end else begin
        st_d.ledOut[i] = 1'b0;
        st_d.ledOe[i] = ledOn[i];
      end
    end
    if (memActive) begin
      st_d.ledOut[0] = (st_q.ld != LD_IDLE) ? st_q.ldDi
                       : st_q.memCtrl[wpc_pkg::MC_DATA];
      st_d.ledOe[0] = 1'b1;
      st_d.ledOut[1] = (st_q.ld != LD_IDLE) ? st_q.ldClk
                       : st_q.memCtrl[wpc_pkg::MC_CLK];
      st_d.ledOe[1] = 1'b1;
      st_d.ledOut[3] = 1'b0;
      st_d.ledOe[3] = 1'b0;
    end
    if (intRst) begin
      st_d.ledOut[1] = 1'b0;
      st_d.ledOe[1] = 1'b0;
    end
    st_d.memSel = (st_q.ld != LD_IDLE) ? st_q.ldSel
                  : st_q.memCtrl[wpc_pkg::MC_SEL];

    // Wake output, indicator, PHY reset, PCI float
    st_d.rwuOut = st_q.wakeCfg[wpc_pkg::WC_TOTEM] ? wakeLevel : 1'b0;
    st_d.rwuOe = wakeDrive &&
                 (st_q.wakeCfg[wpc_pkg::WC_TOTEM] || !wakeLevel);
    st_d.wakeInd = wakeMode;
    st_d.phyRst = intRst ~^ st_q.wakeCfg[wpc_pkg::WC_PHY_POL];
    st_d.pciFloat = !pciRstN;

    // Boot upper address, then strobe rise
    unique case (st_q.bootPh)
      2'd0: begin
        st_d.bootStrobe = 1'b0;
        if (bootAccessStart) begin
          st_d.bootAddr = 8'(bootAddrHigh);
          st_d.bootPh = 2'd1;
        end
      end
      2'd1: begin
        st_d.bootStrobe = 1'b1;
        st_d.bootPh = 2'd2;
      end
      default: begin
        st_d.bootStrobe = 1'b0;
        st_d.bootPh = 2'd0;
      end
    endcase

    // Controller reset while power is good
    if (intRst) begin
      st_d.memCtrl = 3'b000;
      st_d.wakeCfg = wpc_pkg::WAKE_CFG_RST;
      st_d.cfgValid = 1'b0;
      st_d.ledCfg = wpc_pkg::LED_CFG_RST;
      st_d.ld = LD_IDLE;
      st_d.ldSel = 1'b0;
      st_d.ldClk = 1'b0;
      st_d.ldDi = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.waitReq <= 1'b1;
      st_q.ledCfg <= wpc_pkg::LED_CFG_RST;
      st_q.wakeCfg <= wpc_pkg::WAKE_CFG_RST;
      st_q.ld <= LD_IDLE;
      st_q.phyRst <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.readData;
  assign avs_waitrequest = st_q.waitReq;
  assign ledOut = st_q.ledOut;
  assign ledOe = st_q.ledOe;
  assign serialMemSelect = st_q.memSel;
  assign remoteWakeOut = st_q.rwuOut;
  assign remoteWakeOe = st_q.rwuOe;
  assign wakeModeIndicator = st_q.wakeInd;
  assign phyResetOut = st_q.phyRst;
  assign pciPinsFloat = st_q.pciFloat;
  assign bootAddrShared = st_q.bootAddr;
  assign bootAddrStrobe = st_q.bootStrobe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  presence_sample_a: assert property (
    intRst |=> st_q.memPresent == $past(ledRxPinIn))
    else $error("presence flag not sampled");
  presence_hold_a: assert property (
    !intRst |=> $stable(st_q.memPresent))
    else $error("presence flag changed outside reset");
  led_low_drive_a: assert property (
    !st_q.ledCfg[14] && !memActive |=> ledOut[3] == 1'b0)
    else $error("active low LED drove high");
  wake_indicator_a: assert property (
    (!powerGoodIn && st_q.wakeCfg[wpc_pkg::WC_MODE]) |=> wakeModeIndicator)
    else $error("wake mode indicator missing");
  reset_ignored_a: assert property (
    (!powerGoodIn && !pciRstN) |=> pciPinsFloat && $stable(st_q.ledCfg))
    else $error("reset acted while power low");
  phy_reset_a: assert property (
    !powerGoodIn |=> phyResetOut == !$past(st_q.wakeCfg[0]))
    else $error("phy reset asserted while power low");
  wake_hiz_a: assert property (
    !st_q.cfgValid |=> !remoteWakeOe)
    else $error("wake output driven before configuration");
  wake_gate_a: assert property (
    (st_q.wakeCfg[wpc_pkg::WC_GATE] && !powerGoodIn) |=> !remoteWakeOe)
    else $error("gated wake output driven");
  host_select_a: assert property (
    (st_q.ld == LD_IDLE) |=> serialMemSelect == $past(st_q.memCtrl[2]))
    else $error("select not from control bit");

  sequence boot_start_s;
    bootAccessStart && st_q.bootPh == 2'd0;
  endsequence
  sequence boot_strobe_s;
    !bootAddrStrobe ##1 bootAddrStrobe ##1 !bootAddrStrobe;
  endsequence
  boot_strobe_a: assert property (
    boot_start_s |=> boot_strobe_s and
      (bootAddrShared == 8'($past(bootAddrHigh)))[*2])
    else $error("boot address not stable at strobe rise");

  wake_frame_a: assert property (
    (wakeMode && wakeFrameDetected) |=> st_q.wakePend)
    else $error("wake frame not latched");
  wake_link_a: assert property (
    (st_q.wakeCfg[wpc_pkg::WC_LINK_MODE] && linkChangeDetected) |=>
      st_q.wakePend)
    else $error("link change not latched");
  wake_pin_en_a: assert property (
    (!powerGoodIn && st_q.wakeCfg[wpc_pkg::WC_PIN_EN]) |=> wakeModeIndicator)
    else $error("pin enable did not enter wake mode");
  wake_mode_off_a: assert property (
    powerGoodIn |=> !wakeModeIndicator)
    else $error("wake mode indicator while power good");
  loader_clock_a: assert property (
    (st_q.ld != LD_IDLE && !intRst) |=>
      ledOe[1] && ledOut[1] == $past(st_q.ldClk))
    else $error("serial clock not from loader");
  loader_data_a: assert property (
    (st_q.ld != LD_IDLE) |=> ledOe[0] && ledOut[0] == $past(st_q.ldDi))
    else $error("serial data not from loader");
  pci_float_a: assert property (
    !pciRstN |=> pciPinsFloat)
    else $error("pci pins not floated in reset");

endmodule // wpc_pin_control

//--- testbench/wpc_mem_model.sv
`timescale 1ns/1ns
module wpc_mem_model #(
  parameter logic [15:0] WORD = 16'h802B
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       memSel,
  input  wire logic       memClk,
  input  wire logic       bootStrobe,
  input  wire logic [7:0] bootAddr,
  output logic            memDout,
  output logic      [7:0] bootLatch
);
  logic       clkPrev_q;
  logic       flip_q;
  logic [4:0] cnt_q;
  logic       inData;

  // Data bits follow the nine command bits, MSB first
  assign inData  = memSel && (cnt_q >= 5'd9) && (cnt_q <= 5'd24);
  // Outside the data phase the line is not driven: show a toggling level
  assign memDout = inData ? WORD[5'd24 - cnt_q] : flip_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clkPrev_q <= 1'b0;
      flip_q    <= 1'b0;
      cnt_q     <= 5'd0;
    end else begin
      clkPrev_q <= memClk;
      flip_q    <= ~flip_q;
      if (!memSel) begin
        cnt_q <= 5'd0;
      end else if (memClk && !clkPrev_q && cnt_q != 5'd31) begin
        cnt_q <= cnt_q + 5'd1;
      end
    end
  end

  // Board latch of the upper boot address
  always @(posedge bootStrobe) begin
    bootLatch <= bootAddr;
  end
endmodule // wpc_mem_model

//--- testbench/wake_power_eeprom_pin_control_tb_top.sv
`timescale 1ns/1ns
module wake_power_eeprom_pin_control_tb_top;
  logic core_clk = 1'b0, resetn = 1'b0, pciRstN = 1'b0, powerGoodIn = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, netStatus = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, ledRxPinIn = 1'b1;
  logic [31:0] avs_writedata = 32'h0000_0000, rdat;
  logic timebaseSelect = 1'b1, extClk = 1'b0, wakeFrame = 1'b0;
  logic bootStart = 1'b0, memDout, remoteWakeOut, remoteWakeOe;
  logic [3:0] bootHigh = 4'h0, ledOut, ledOe;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, serialMemSelect, wakeModeIndicator, phyResetOut;
  logic pciPinsFloat, bootStrobe, linkChg = 1'b0;
  logic [7:0] bootShared, bootLatch;
  int errors = 0, n_checks = 0, k;

  wpc_pin_control uut (
    .core_clk(core_clk), .resetn(resetn), .pciRstN(pciRstN),
    .powerGoodIn(powerGoodIn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .netStatus(netStatus), .ledRxPinIn(ledRxPinIn), .ledTxPinIn(memDout),
    .ledOut(ledOut), .ledOe(ledOe), .serialMemSelect(serialMemSelect),
    .timebaseSelect(timebaseSelect), .timebaseExtClock(extClk),
    .wakeFrameDetected(wakeFrame), .linkChangeDetected(linkChg),
    .remoteWakeOut(remoteWakeOut), .remoteWakeOe(remoteWakeOe),
    .wakeModeIndicator(wakeModeIndicator), .phyResetOut(phyResetOut),
    .pciPinsFloat(pciPinsFloat), .bootAccessStart(bootStart),
    .bootAddrHigh(bootHigh), .bootAddrShared(bootShared),
    .bootAddrStrobe(bootStrobe));

  wpc_mem_model mem (
    .core_clk(core_clk), .resetn(resetn), .memSel(serialMemSelect),
    .memClk(ledOut[1]), .bootStrobe(bootStrobe), .bootAddr(bootShared),
    .memDout(memDout), .bootLatch(bootLatch));

  initial begin
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #10;
    forever #60 extClk = ~extClk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int c;
    c = 0;
    @(posedge core_clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      c++;
    end while (avs_waitrequest !== 1'b0 && c < 50);
    if (c >= 50) chk("waitrequest", 32'h1, 32'h0);
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_load;
    repeat (4) @(posedge core_clk);
    k = 0;
    do begin
      bus(1'b0, wpc_pkg::ADDR_MEM_CTRL, 32'h0000_0000);
      k++;
    end while (rdat[wpc_pkg::MC_BUSY] !== 1'b0 && k < 200);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("wakeOe", remoteWakeOe, 32'h0);
    repeat (30) @(posedge core_clk);
    chk("phyRst", phyResetOut, 32'h0);
    pciRstN <= 1'b1;
    wait_load();
    chk("present", rdat[wpc_pkg::MC_PRESENT], 32'h1);
    bus(1'b0, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_0000);
    chk("wakeCfg", rdat, 32'h0000_012B);
    chk("phyRst", phyResetOut, 32'h0);
    chk("wakeOe", remoteWakeOe, 32'h1);
    timebaseSelect <= 1'b0;
    $display("test load done");
    bus(1'b0, wpc_pkg::ADDR_LED_CFG, 32'h0000_0000);
    chk("ledCfg", rdat, 32'h0000_3210);
    netStatus <= 4'h8;
    repeat (3) @(posedge core_clk);
    chk("ledTx", {ledOe, ledOut}, 32'h80);
    bus(1'b1, wpc_pkg::ADDR_LED_CFG, 32'h0000_7210);
    repeat (3) @(posedge core_clk);
    chk("ledHigh", {ledOe[3], ledOut[3]}, 32'h3);
    $display("test led done");
    bus(1'b1, wpc_pkg::ADDR_MEM_CTRL, 32'h0000_0005);
    repeat (2) @(posedge core_clk);
    chk("memPins", {serialMemSelect, ledOut[1:0]}, 32'h5);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, wpc_pkg::ADDR_MEM_CTRL, 32'h0000_0007);
      repeat (2) @(posedge core_clk);
      chk("memClk", ledOut[1:0], 32'h3);
      bus(1'b1, wpc_pkg::ADDR_MEM_CTRL, 32'h0000_0005);
    end
    bus(1'b0, wpc_pkg::ADDR_MEM_CTRL, 32'h0000_0000);
    chk("dataOut", rdat[wpc_pkg::MC_DATA], 32'h1);
    bus(1'b1, wpc_pkg::ADDR_MEM_CTRL, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("memSel", serialMemSelect, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk("unmapped", rdat, 32'h0);
    $display("test host done");
    bus(1'b1, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_001B);
    powerGoodIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("wakeMode", wakeModeIndicator, 32'h1);
    chk("wakeIdle", remoteWakeOut, 32'h0);
    wakeFrame <= 1'b1;
    @(posedge core_clk);
    wakeFrame <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("wakeOut", {remoteWakeOe, remoteWakeOut}, 32'h3);
    pciRstN <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk("pciFloat", pciPinsFloat, 32'h1);
    chk("phyRst", phyResetOut, 32'h0);
    bus(1'b0, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_0000);
    chk("wakeKeep", rdat, 32'h0000_071B);
    bus(1'b1, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_001F);
    repeat (3) @(posedge core_clk);
    chk("wakeGate", remoteWakeOe, 32'h0);
    pciRstN <= 1'b1;
    powerGoodIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("wakeMode", wakeModeIndicator, 32'h0);
    bus(1'b1, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_0020);
    powerGoodIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("pinEn", wakeModeIndicator, 32'h1);
    powerGoodIn <= 1'b1;
    $display("test wake done");
    ledRxPinIn <= 1'b0;
    pciRstN <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk("phyRst", phyResetOut, 32'h0);
    pciRstN <= 1'b1;
    wait_load();
    chk("absent", rdat & 32'h18, 32'h0);
    linkChg <= 1'b1;
    @(posedge core_clk);
    linkChg <= 1'b0;
    bus(1'b0, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_0000);
    chk("wakeCfg", rdat, 32'h0000_0100);
    $display("test absent done");
    bus(1'b1, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_004A);
    linkChg <= 1'b1;
    @(posedge core_clk);
    linkChg <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("linkWake", {remoteWakeOe, remoteWakeOut}, 32'h3);
    $display("test link done");
    ledRxPinIn <= 1'b1;
    pciRstN <= 1'b0;
    repeat (30) @(posedge core_clk);
    pciRstN <= 1'b1;
    wait_load();
    bus(1'b0, wpc_pkg::ADDR_WAKE_CFG, 32'h0000_0000);
    chk("divLoad", rdat, 32'h0000_012B);
    $display("test divider done");
    bootHigh  <= 4'hA;
    bootStart <= 1'b1;
    @(posedge core_clk);
    bootStart <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("bootHi", bootLatch[3:0], 32'hA);
    $display("test boot done");
    end_sim();
  end
endmodule // wake_power_eeprom_pin_control_tb_top
